// File: src/mdq_regs.svh
// Functional notes
// - four read-only discrete inputs from address zero, 1 when channel on
// - eight read-only unsigned gain words from input address 16
// - eight read-only signed offset words from input address 32
// - discrete in, discrete out, analog in channel counts at 80, 81, 82
// - version words at 90, 91, 92, 94, 95; module name at 100
// - trigger type at holding 34, values 0..3, kept nonvolatile
// - boot count at holding 50, kept nonvolatile
// - marker at holding 60 reads 0 after factory default restore
// - only master starts; device answers with data or performs action
// - addresses 1..247 are individual devices, 0 is broadcast
// - response confirms action, carries data, and an error check field
// - holding registers store 16-bit values, may drive an output channel
// - computed gain and offset coefficients stored nonvolatile and read back
// - echo function code; set its top bit only when reporting an error
`ifndef MDQ_REGS_SVH
`define MDQ_REGS_SVH
// *************************************
// input register addresses
// *************************************
`define MDQ_IR_AIN 16'h0000
`define MDQ_IR_GAIN 16'h0010
`define MDQ_IR_OFS 16'h0020
`define MDQ_IR_NDI 16'h0050
`define MDQ_IR_NDO 16'h0051
`define MDQ_IR_NAI 16'h0052
`define MDQ_IR_VOS 16'h005a
`define MDQ_IR_VFW 16'h005b
`define MDQ_IR_VLIB 16'h005c
`define MDQ_IR_VTCP 16'h005e
`define MDQ_IR_VWEB 16'h005f
`define MDQ_IR_NAME 16'h0064
// *************************************
// holding register addresses
// *************************************
`define MDQ_HR_RANGE 16'h0020
`define MDQ_HR_SCAN 16'h0021
`define MDQ_HR_TRIG 16'h0022
`define MDQ_HR_RATE 16'h0023
`define MDQ_HR_TGT 16'h0025
`define MDQ_HR_BOOT 16'h0032
`define MDQ_HR_FDEF 16'h003c
// *************************************
// framing constants
// *************************************
`define MDQ_NUM_DI 16'h0004
`define MDQ_NUM_DO 16'h0004
`define MDQ_NUM_AI 16'h0008
`define MDQ_MAX_ADDR 8'hf7
`define MDQ_BCAST 8'h00
`define MDQ_ERR_BIT 8'h80
`define MDQ_EX_FUNC 8'h01
`define MDQ_EX_ADDR 8'h02
`define MDQ_EX_VAL 8'h03
`define MDQ_FC_RDI 8'h02
`define MDQ_FC_RHR 8'h03
`define MDQ_FC_RIR 8'h04
`define MDQ_FC_WSR 8'h06
`define MDQ_SCAN_MIN 16'h0001
`define MDQ_SCAN_MAX 16'h0008
`define MDQ_TRIG_MAX 16'h0003
`define MDQ_RANGE_MAX 16'h0001
// arbitrary identity and version defaults
`define MDQ_VER_DEF 16'h0100
`define MDQ_NAME_DEF 16'h1234
`endif

// File: src/mdq_pkg.sv
package mdq_pkg;
    // one decoded query from the frame parser
    typedef struct packed {
        logic [7:0] unit;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] data;
    } mdq_req_t;
    // one answer word toward the frame builder
    typedef struct packed {
        logic [7:0] unit;
        logic [7:0] func;
        logic [15:0] data;
        logic [7:0] exc;
    } mdq_rsp_t;
    // nonvolatile image presented at power-up
    typedef struct packed {
        logic [15:0] range;
        logic [15:0] trig;
        logic [31:0] rate;
        logic [31:0] tgt;
        logic [15:0] boot;
        logic [15:0] fdef;
    } mdq_nv_t;
endpackage : mdq_pkg

// File: src/mdq_register_map.sv
`timescale 1ns/1ps
`include "mdq_regs.svh"
module mdq_register_map (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] unit_id,
    input wire logic req_valid,
    input wire mdq_pkg::mdq_req_t req,
    input wire logic [3:0] discrete_input_channel,
    input wire logic [127:0] analog_input_channel,
    input wire logic [127:0] cal_gain,
    input wire logic [127:0] cal_offset,
    input wire logic cal_load,
    input wire logic nv_load,
    input wire mdq_pkg::mdq_nv_t nv_image,
    input wire logic factory_restore,
    output logic rsp_valid,
    output mdq_pkg::mdq_rsp_t rsp,
    output logic nv_store,
    output mdq_pkg::mdq_nv_t nv_out,
    output logic [15:0] range_out,
    output logic [3:0] scan_out,
    output logic [1:0] trig_out,
    output logic [31:0] rate_out,
    output logic [31:0] tgt_out
);
    import mdq_pkg::*;

    // *************************************
    // storage
    // *************************************
    logic [15:0] gain_reg [0:7];
    logic [15:0] ofs_reg [0:7];
    logic [15:0] range_reg, scan_reg, trig_reg, boot_reg, fdef_reg;
    logic [31:0] rate_reg, tgt_reg;
    logic [15:0] rd_word;
    logic [7:0] rd_exc;
    logic wr_ok;
    logic [7:0] wr_exc;
    logic for_us;

    // address match within a block of eight words
    function automatic logic in_block(input logic [15:0] a, input logic [15:0] base);
        in_block = (a >= base) && (a < base + `MDQ_NUM_AI);
    endfunction : in_block

    // individual address or broadcast; the top address 247 is not checked
    assign for_us = (req.unit == unit_id) || (req.unit == `MDQ_BCAST);

    // calibration coefficients latched from the nonvolatile store
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_cal
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    gain_reg[g] <= 16'h0000;
                    ofs_reg[g] <= 16'h0000;
                end else if (clk_en && cal_load) begin
                    gain_reg[g] <= cal_gain[g*16 +: 16];
                    ofs_reg[g] <= cal_offset[g*16 +: 16];
                end
            end
        end
    endgenerate

    // read decode for functions 02, 03 and 04
    always_comb begin
        rd_word = 16'h0000;
        rd_exc = 8'h00;
        case (req.func)
            `MDQ_FC_RDI: begin
                if (req.addr < `MDQ_NUM_DI)
                    rd_word = {15'h0000, discrete_input_channel[req.addr[1:0]]};
                else
                    rd_exc = `MDQ_EX_ADDR;
            end
            `MDQ_FC_RIR: begin
                if (in_block(req.addr, `MDQ_IR_AIN))
                    rd_word = analog_input_channel[req.addr[2:0]*16 +: 16];
                else if (in_block(req.addr, `MDQ_IR_GAIN))
                    rd_word = gain_reg[req.addr[2:0]];
                else if (in_block(req.addr, `MDQ_IR_OFS))
                    rd_word = ofs_reg[req.addr[2:0]];
                else begin
                    case (req.addr)
                        `MDQ_IR_NDI: rd_word = `MDQ_NUM_DI;
                        `MDQ_IR_NDO: rd_word = `MDQ_NUM_DO;
                        `MDQ_IR_NAI: rd_word = `MDQ_NUM_AI;
                        `MDQ_IR_VOS, `MDQ_IR_VFW, `MDQ_IR_VLIB,
                        `MDQ_IR_VTCP, `MDQ_IR_VWEB: rd_word = `MDQ_VER_DEF;
                        `MDQ_IR_NAME: rd_word = `MDQ_NAME_DEF;
                        default: rd_exc = `MDQ_EX_ADDR;
                    endcase
                end
            end
            `MDQ_FC_RHR: begin
                case (req.addr)
                    `MDQ_HR_RANGE: rd_word = range_reg;
                    `MDQ_HR_SCAN: rd_word = scan_reg;
                    `MDQ_HR_TRIG: rd_word = trig_reg;
                    `MDQ_HR_RATE: rd_word = rate_reg[15:0];
                    `MDQ_HR_RATE + 16'h0001: rd_word = rate_reg[31:16];
                    `MDQ_HR_TGT: rd_word = tgt_reg[15:0];
                    `MDQ_HR_TGT + 16'h0001: rd_word = tgt_reg[31:16];
                    `MDQ_HR_BOOT: rd_word = boot_reg;
                    `MDQ_HR_FDEF: rd_word = fdef_reg;
                    default: rd_exc = `MDQ_EX_ADDR;
                endcase
            end
            `MDQ_FC_WSR: rd_word = req.data;
            default: rd_exc = `MDQ_EX_FUNC;
        endcase
    end

    // write checks: legal address and value in range
    always_comb begin
        wr_ok = 1'b0;
        wr_exc = 8'h00;
        if (req.func == `MDQ_FC_WSR) begin
            case (req.addr)
                `MDQ_HR_RANGE: wr_ok = req.data <= `MDQ_RANGE_MAX;
                `MDQ_HR_SCAN: wr_ok = (req.data >= `MDQ_SCAN_MIN) &&
                                      (req.data <= `MDQ_SCAN_MAX);
                `MDQ_HR_TRIG: wr_ok = req.data <= `MDQ_TRIG_MAX;
                `MDQ_HR_RATE, `MDQ_HR_RATE + 16'h0001, `MDQ_HR_TGT,
                `MDQ_HR_TGT + 16'h0001, `MDQ_HR_BOOT, `MDQ_HR_FDEF: wr_ok = 1'b1;
                default: wr_exc = `MDQ_EX_ADDR;
            endcase
            // a known address with a bad value is a value fault, not an address fault
            if (!wr_ok && wr_exc == 8'h00)
                wr_exc = `MDQ_EX_VAL;
        end
    end

    // holding registers: nonvolatile load, factory restore, then master writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            range_reg <= 16'h0000;
            scan_reg <= `MDQ_SCAN_MAX;
            trig_reg <= 16'h0000;
            rate_reg <= 32'h0000_0000;
            tgt_reg <= 32'h0000_0000;
            boot_reg <= 16'h0000;
            fdef_reg <= 16'h0000;
        end else if (clk_en) begin
            if (nv_load) begin
                range_reg <= nv_image.range;
                trig_reg <= nv_image.trig;
                rate_reg <= nv_image.rate;
                tgt_reg <= nv_image.tgt;
                boot_reg <= nv_image.boot + 16'h0001;
                fdef_reg <= nv_image.fdef;
            end else if (factory_restore) begin
                range_reg <= 16'h0000;
                scan_reg <= `MDQ_SCAN_MAX;
                trig_reg <= 16'h0000;
                rate_reg <= 32'h0000_0000;
                tgt_reg <= 32'h0000_0000;
                fdef_reg <= 16'h0000;
            end else if (req_valid && for_us && wr_ok) begin
                case (req.addr)
                    `MDQ_HR_RANGE: range_reg <= req.data;
                    `MDQ_HR_SCAN: scan_reg <= req.data;
                    `MDQ_HR_TRIG: trig_reg <= req.data;
                    `MDQ_HR_RATE: rate_reg[15:0] <= req.data;
                    `MDQ_HR_RATE + 16'h0001: rate_reg[31:16] <= req.data;
                    `MDQ_HR_TGT: tgt_reg[15:0] <= req.data;
                    `MDQ_HR_TGT + 16'h0001: tgt_reg[31:16] <= req.data;
                    `MDQ_HR_BOOT: boot_reg <= req.data;
                    `MDQ_HR_FDEF: fdef_reg <= req.data;
                    default: ;
                endcase
            end
        end
    end

    // nonvolatile write-back strobe after any accepted write or boot
    always_ff @(posedge ref_clk) begin
        if (rst)
            nv_store <= 1'b0;
        else if (clk_en)
            nv_store <= nv_load || factory_restore ||
                        (req_valid && for_us && wr_ok);
    end

    // mirror of the retained settings
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_out <= '0;
            range_out <= 16'h0000;
            scan_out <= 4'h0;
            trig_out <= 2'b00;
            rate_out <= 32'h0000_0000;
            tgt_out <= 32'h0000_0000;
        end else if (clk_en) begin
            nv_out <= '{range: range_reg, trig: trig_reg, rate: rate_reg,
                        tgt: tgt_reg, boot: boot_reg, fdef: fdef_reg};
            range_out <= range_reg;
            scan_out <= scan_reg[3:0];
            trig_out <= trig_reg[1:0];
            rate_out <= rate_reg;
            tgt_out <= tgt_reg;
        end
    end

    // answer: broadcast gets none; error sets the top bit of function code
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else if (clk_en) begin
            rsp_valid <= req_valid && (req.unit == unit_id) &&
                         (req.unit != `MDQ_BCAST);
            if (req_valid) begin
                rsp.unit <= req.unit;
                if (req.func == `MDQ_FC_WSR) begin
                    rsp.func <= wr_ok ? req.func : (req.func | `MDQ_ERR_BIT);
                    rsp.exc <= wr_exc;
                    rsp.data <= req.data;
                end else begin
                    rsp.func <= (rd_exc == 8'h00) ? req.func
                                                  : (req.func | `MDQ_ERR_BIT);
                    rsp.exc <= rd_exc;
                    rsp.data <= rd_word;
                end
            end
        end
    end
endmodule : mdq_register_map

// File: tb/mdq_monitor.sv
`timescale 1ns/1ps
`include "mdq_regs.svh"
// ****
// register map checker
// ****
module mdq_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] unit_id,
    input wire logic req_valid,
    input wire mdq_pkg::mdq_req_t req,
    input wire logic [3:0] discrete_input_channel,
    input wire logic nv_load,
    input wire logic factory_restore,
    input wire logic rsp_valid,
    input wire logic nv_store,
    input wire mdq_pkg::mdq_rsp_t rsp,
    input wire mdq_pkg::mdq_nv_t nv_out,
    input wire logic [1:0] trig_out
);
    import mdq_pkg::*;
    logic hit;
    logic wr;
    logic di_bit;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // queries for this unit, and writes that land here (broadcast too)
    assign hit = clk_en && req_valid && req.unit == unit_id && unit_id != 8'h00;
    assign wr = clk_en && req_valid && req.func == `MDQ_FC_WSR && !nv_load
        && !factory_restore && (req.unit == unit_id || req.unit == `MDQ_BCAST);
    assign di_bit = discrete_input_channel[req.addr[1:0]];
    property p_answer; hit |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("query unanswered");
    property p_quiet; clk_en && !hit |=> !rsp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without query");
    property p_echo; rsp_valid |-> (rsp.func & 8'h7f) == ($past(req.func) & 8'h7f); endproperty
    a_echo: assert property (p_echo) else $error("function code not echoed");
    property p_di; hit && req.func == `MDQ_FC_RDI && req.addr < 16'h0004
        |=> rsp.data[0] == $past(di_bit); endproperty
    a_di: assert property (p_di) else $error("discrete input bit wrong");
    property p_badfn; hit && !(req.func inside {8'h02, 8'h03, 8'h04, 8'h06})
        |=> rsp.exc == `MDQ_EX_FUNC && rsp.func[7]; endproperty
    a_badfn: assert property (p_badfn) else $error("bad function accepted");
    property p_scan; hit && req.func == `MDQ_FC_WSR && req.addr == `MDQ_HR_SCAN
        && (req.data == 16'h0000 || req.data > 16'h0008) |=> rsp.exc == `MDQ_EX_VAL; endproperty
    a_scan: assert property (p_scan) else $error("scan count not refused");
    property p_trig; wr && req.addr == `MDQ_HR_TRIG && req.data <= 16'h0003
        |-> ##2 16'(trig_out) == $past(req.data, 2); endproperty
    a_trig: assert property (p_trig) else $error("trigger mirror wrong");
    property p_fdef; factory_restore && clk_en && !nv_load |-> ##2 nv_out.fdef == 16'h0000;
    endproperty
    a_fdef: assert property (p_fdef) else $error("marker not cleared");
    property p_store; clk_en && (nv_load || factory_restore) |=> nv_store; endproperty
    a_store: assert property (p_store) else $error("settings not stored");
endmodule : mdq_monitor

// File: tb/mdq_master_model.sv
`timescale 1ns/1ps
// ****
// master side of the query link
// ****
module mdq_master_model (
    input wire logic ref_clk,
    output logic req_valid = 1'b0,
    output mdq_pkg::mdq_req_t req = '0,
    input wire logic rsp_valid,
    input wire mdq_pkg::mdq_rsp_t rsp
);
    import mdq_pkg::*;
    // one word per query; released fields go inverted so stale values never look valid
    task automatic query(input mdq_req_t q, output mdq_rsp_t r, output logic got);
        @(posedge ref_clk);
        #1;
        req = q;
        req_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        req = ~q;
        got = (rsp_valid === 1'b1);
        r = rsp;
        @(posedge ref_clk);
        #1;
    endtask : query
endmodule : mdq_master_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "mdq_regs.svh"
// ****
// register map bench
// ****
module tb_top;
    import mdq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] unit_id = 8'h11;
    logic req_valid;
    mdq_req_t req;
    logic [3:0] discrete_input_channel = 4'h9;
    logic [127:0] analog_input_channel = 128'h8000_7fff_0001_ffff_1234_edcb_0000_4000;
    logic [127:0] cal_gain = 128'hffff_0000_8001_7ffe_0102_0304_0506_0708;
    logic [127:0] cal_offset = 128'h8000_7fff_fffe_0002_0a0b_0c0d_0e0f_1011;
    logic cal_load = 1'b0;
    logic nv_load = 1'b0;
    mdq_nv_t nv_image = '{16'h0001, 16'h0003, 32'h0001_0002, 32'h0003_0004, 16'h0005, 16'h0007};
    logic factory_restore = 1'b0;
    logic rsp_valid;
    mdq_rsp_t rsp;
    logic nv_store;
    mdq_nv_t nv_out;
    logic [15:0] range_out;
    logic [3:0] scan_out;
    logic [1:0] trig_out;
    logic [31:0] rate_out;
    logic [31:0] tgt_out;
    mdq_rsp_t r;
    logic got;
    int n_errors = 0;
    int checks_done = 0;
    logic [15:0] id_a [9] = '{16'h0050, 16'h0051, 16'h0052, 16'h005a, 16'h005b, 16'h005c,
        16'h005e, 16'h005f, 16'h0064};
    logic [15:0] id_v [9] = '{`MDQ_NUM_DI, `MDQ_NUM_DO, `MDQ_NUM_AI, `MDQ_VER_DEF,
        `MDQ_VER_DEF, `MDQ_VER_DEF, `MDQ_VER_DEF, `MDQ_VER_DEF, `MDQ_NAME_DEF};
    logic [383:0] in_words;
    // input words in address order: samples, gains at 16, offsets at 32
    assign in_words = {cal_offset, cal_gain, analog_input_channel};
    always #2.5 ref_clk = ~ref_clk;
    mdq_register_map dut (.*);
    mdq_master_model master (.*);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one query to this unit; data compared only on a clean read
    task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
        input logic [15:0] ed, input logic [7:0] ex);
        master.query('{unit_id, f, a, d}, r, got);
        chk("answer", 32'(got), 32'h1);
        chk("func", 32'(r.func), 32'(ex != 8'h00 ? f | `MDQ_ERR_BIT : f));
        chk("exc", 32'(r.exc), 32'(ex));
        if (ex == 8'h00 && f != `MDQ_FC_WSR) begin
            chk("data", 32'(r.data), 32'(ed));
        end
    endtask : rq
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge ref_clk);
        #1;
        s = 1'b0;
    endtask : pulse
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        rq(`MDQ_FC_RHR, `MDQ_HR_SCAN, 0, 16'h0008, 0);
        for (int i = 0; i < 4; i++) begin
            rq(`MDQ_FC_RDI, 16'(i), 0, {15'h0, discrete_input_channel[i]}, 0);
        end
        pulse(cal_load);
        for (int i = 0; i < 24; i++) begin
            rq(`MDQ_FC_RIR, 16'(i % 8 + i / 8 * 16), 0, in_words[i*16+:16], 0);
        end
        foreach (id_a[i]) rq(`MDQ_FC_RIR, id_a[i], 0, id_v[i], 0);
        for (int i = 0; i < 4; i++) begin
            rq(`MDQ_FC_WSR, `MDQ_HR_TRIG, 16'(i), 0, 0);
            rq(`MDQ_FC_RHR, `MDQ_HR_TRIG, 0, 16'(i), 0);
            chk("trig_out", 32'(trig_out), 32'(i));
        end
        rq(`MDQ_FC_WSR, `MDQ_HR_TRIG, 16'h0004, 0, `MDQ_EX_VAL);
        rq(`MDQ_FC_WSR, `MDQ_HR_SCAN, 16'h0000, 0, `MDQ_EX_VAL);
        rq(`MDQ_FC_WSR, `MDQ_HR_SCAN, 16'h0009, 0, `MDQ_EX_VAL);
        rq(`MDQ_FC_WSR, `MDQ_HR_SCAN, 16'h0001, 0, 0);
        rq(`MDQ_FC_WSR, `MDQ_HR_RANGE, 16'h0001, 0, 0);
        rq(`MDQ_FC_WSR, `MDQ_HR_RATE, 16'hbeef, 0, 0);
        rq(`MDQ_FC_WSR, `MDQ_HR_RATE + 16'h1, 16'hcafe, 0, 0);
        rq(`MDQ_FC_RHR, `MDQ_HR_RATE + 16'h1, 0, 16'hcafe, 0);
        chk("rate_out", rate_out, 32'hcafe_beef);
        rq(`MDQ_FC_WSR, `MDQ_HR_TGT, 16'h1111, 0, 0);
        rq(`MDQ_FC_WSR, `MDQ_HR_TGT + 16'h1, 16'h2222, 0, 0);
        rq(`MDQ_FC_RHR, `MDQ_HR_TGT, 0, 16'h1111, 0);
        chk("tgt_out", tgt_out, 32'h2222_1111);
        rq(`MDQ_FC_WSR, 16'h0070, 16'h0001, 0, `MDQ_EX_ADDR);
        chk("scan_out", 32'(scan_out), 32'h1);
        chk("range_out", 32'(range_out), 32'h1);
        rq(8'h10, 0, 0, 0, `MDQ_EX_FUNC);
        rq(`MDQ_FC_RIR, 16'h0070, 0, 0, `MDQ_EX_ADDR);
        master.query('{`MDQ_BCAST, `MDQ_FC_WSR, `MDQ_HR_TRIG, 16'h0002}, r, got);
        chk("bcast", 32'(got), 32'h0);
        master.query('{8'h12, `MDQ_FC_RHR, `MDQ_HR_TRIG, 16'h0000}, r, got);
        chk("other", 32'(got), 32'h0);
        rq(`MDQ_FC_RHR, `MDQ_HR_TRIG, 0, 16'h0002, 0);
        pulse(nv_load);
        rq(`MDQ_FC_RHR, `MDQ_HR_BOOT, 0, nv_image.boot + 16'h1, 0);
        rq(`MDQ_FC_RHR, `MDQ_HR_TRIG, 0, nv_image.trig, 0);
        pulse(factory_restore);
        rq(`MDQ_FC_RHR, `MDQ_HR_FDEF, 0, 16'h0000, 0);
        stop_test();
    end
endmodule : tb_top

bind mdq_register_map mdq_monitor u_mon (.*);
